// File: design/vse_pkg.sv
// constants and types for the vertical sync extractor
//
// Overview of operation
// - csync_out shows only video below black level, never picture content.
// - slicing sits a fixed 70 mV above the clamped tip at any amplitude.
// - charge only in sync, so line pulses stay under serration_threshold.
// - a broad pulse passes serration_threshold but not default_threshold.
// - the serration comparator is sampled into a flop as each pulse ends.
// - a high sample sets the vertical latch via an OR; it drives vsync_out.
// - the oscillator runs only while latched; the rise clocks field parity.
// - the oscillator is divided by eight and the latch clears after eight.
// - oscillator period and charge rate both scale with timing_resistor.
// - an integrator that never passes serration_threshold gives no pulse.
// - after an eight-cycle pulse ends, a later serration may retrigger.
// - with no serration edge, default_threshold sets the latch via the OR.
// - a default pulse ended early is retriggered when the broad pulse ends.
// - field_odd_out is low through the even field, high through the odd.
package vse_pkg;
  localparam int CLK_MHZ         = 50;
  localparam int CLK_PERIOD_NS   = 20;
  localparam int VID_W           = 8;
  localparam int RES_W           = 8;
  localparam int INT_W           = 8;
  localparam int TICK_W          = 13;
  localparam int DIV_W           = 3;
  localparam int GAP_W           = 12;
  localparam int DEC_W           = 6;
  // one code of an 8-bit converter spanning 2 V, in microvolts
  localparam int LSB_UV          = 7813;
  localparam int SLICE_OFFSET_MV = 70;
  localparam logic [VID_W:0] SLICE_OFFSET_CODES =
    (VID_W+1)'((SLICE_OFFSET_MV * 1000 + LSB_UV - 1) / LSB_UV);
  localparam int CLAMP_DECAY_NS  = 1000;
  localparam logic [DEC_W-1:0] CLAMP_DECAY_CYC =
    DEC_W'(CLAMP_DECAY_NS / CLK_PERIOD_NS);
  localparam logic [VID_W-1:0] TIP_RESET = 8'hff;
  // serration threshold kept below the default threshold
  localparam logic [INT_W-1:0] SERR_THR = 8'h0c;
  localparam logic [INT_W-1:0] DFLT_THR = 8'h28;
  localparam logic [INT_W-1:0] INT_MAX  = 8'hff;
  localparam logic [TICK_W-1:0] INT_SCALE = 13'h0001;
  localparam logic [TICK_W-1:0] OSC_SCALE = 13'h0015;
  localparam logic [DIV_W-1:0] DIV_LAST = 3'h7;
  // gap between sync starts that marks a full line, not a half line
  localparam int PARITY_GAP_US   = 48;
  localparam logic [GAP_W-1:0] PARITY_GAP_CYC =
    GAP_W'(PARITY_GAP_US * CLK_MHZ);

  typedef enum logic [1:0] {
    VSE_IDLE  = 2'b01,
    VSE_PULSE = 2'b10
  } vse_vstate_type;
endpackage

// File: design/vse_tick_gen.sv
// programmable tick divider, cleared while not running
`timescale 1ns/1ps
module vse_tick_gen
  import vse_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // control
  input  wire logic                      run,
  input  wire logic [vse_pkg::TICK_W-1:0] period,
  // tick
  output logic                           tick
);
  logic [TICK_W-1:0] cnt_r;
  logic [TICK_W-1:0] cnt_nxt;
  logic              tick_r;
  logic              wrap;

  assign wrap    = run && (cnt_r >= period - 13'h0001);
  assign cnt_nxt = (!run || wrap) ? 13'h0000 : cnt_r + 13'h0001;
  assign tick    = tick_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r  <= 13'h0000;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      tick_r <= wrap;
    end
  end

  a_tick_gated: assert property (@(posedge clk) disable iff (rst)
    tick_r |-> $past(run)) else $error("tick without run");
endmodule // vse_tick_gen

// File: design/vse_integrator.sv
// saturating sync integrator with its two comparators
`timescale 1ns/1ps
module vse_integrator
  import vse_pkg::*;
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // charge control
  input  wire logic                     charge,
  input  wire logic                     step,
  // level and comparators
  output logic [vse_pkg::INT_W-1:0]     level,
  output logic                          above_serr,
  output logic                          above_dflt
);
  logic [INT_W-1:0] level_r;
  logic [INT_W-1:0] level_nxt;

  assign level_nxt  = !charge ? 8'h00 :
                      (step && level_r != INT_MAX) ?
                      level_r + 8'h01 : level_r;
  assign level      = level_r;
  assign above_serr = level_r > SERR_THR;
  assign above_dflt = level_r >= DFLT_THR;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      level_r <= 8'h00;
    else
      level_r <= level_nxt;
  end

  a_integ_clear: assert property (@(posedge clk) disable iff (rst)
    !charge |=> level_r == 8'h00) else $error("integrator not cleared");
  a_integ_count: assert property (@(posedge clk) disable iff (rst)
    charge && step && level_r != INT_MAX |=>
    level_r == $past(level_r) + 8'h01) else $error("no count step");
endmodule // vse_integrator

// File: design/vse_sync_extractor.sv
// composite sync slicer, vertical pulse generator and field parity
`timescale 1ns/1ps
module vse_sync_extractor
  import vse_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // video samples, sync tip is the low end
  input  wire logic [vse_pkg::VID_W-1:0] video_in,
  // timing setting, larger means slower
  input  wire logic [vse_pkg::RES_W-1:0] timing_resistor,
  // sync outputs
  output logic                           csync_out,
  output logic                           vsync_out,
  output logic                           field_odd_out
);
  import vse_pkg::*;

  // input stage and clamp
  logic [VID_W-1:0]  vid_r;
  logic [VID_W-1:0]  tip_r;
  logic [VID_W-1:0]  tip_nxt;
  logic [DEC_W-1:0]  dec_cnt_r;
  logic [DEC_W-1:0]  dec_cnt_nxt;
  logic              dec_done;
  logic [VID_W:0]    thr_sum;
  logic [VID_W-1:0]  thr_sat;
  logic              below_thr;

  // sync edges
  logic              csync_r;
  logic              csync_prev_r;
  logic              sync_start;
  logic              sync_end;

  // timing rates
  logic [RES_W-1:0]  res_eff;
  logic [TICK_W-1:0] int_period;
  logic [TICK_W-1:0] osc_period;
  logic              int_tick;
  logic              osc_tick;
  logic              osc_run;

  // integrator and vertical latch
  logic [INT_W-1:0]  integ_level;
  logic              above_serr;
  logic              above_dflt;
  logic              dflt_prev_r;
  logic              dflt_rise;
  logic              sample_r;
  logic              sample_nxt;
  logic              samp_set;
  logic              set_term;
  logic              div_end;
  vse_vstate_type    vstate_r;
  vse_vstate_type    vstate_nxt;
  logic [DIV_W-1:0]  div_cnt_r;
  logic [DIV_W-1:0]  div_cnt_nxt;
  logic              vsync_r;
  logic              vsync_rise;

  // field parity
  logic [GAP_W-1:0]  gap_cnt_r;
  logic [GAP_W-1:0]  gap_cnt_nxt;
  logic              half_r;
  logic              half_nxt;
  logic              long_gap;
  logic              field_odd_r;
  logic              field_odd_nxt;

  // clamp: fast follow down to the tip, slow drift up so that
  // a change of level or amplitude is relearned within a field
  assign dec_done    = dec_cnt_r == CLAMP_DECAY_CYC;
  assign dec_cnt_nxt = dec_done ? 6'h00 : dec_cnt_r + 6'h01;
  assign tip_nxt     = (vid_r < tip_r) ? vid_r :
                       (dec_done && tip_r != TIP_RESET) ?
                       tip_r + 8'h01 : tip_r;

  // slicing level rides a fixed offset above the tip
  assign thr_sum   = {1'b0, tip_r} + SLICE_OFFSET_CODES;
  assign thr_sat   = thr_sum[VID_W] ? TIP_RESET : thr_sum[VID_W-1:0];
  assign below_thr = vid_r <= thr_sat;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      vid_r     <= 8'hff;
      tip_r     <= TIP_RESET;
      dec_cnt_r <= 6'h00;
    end
    else
    begin
      vid_r     <= video_in;
      tip_r     <= tip_nxt;
      dec_cnt_r <= dec_cnt_nxt;
    end
  end

  // sync edges
  assign sync_start = csync_r && !csync_prev_r;
  assign sync_end   = !csync_r && csync_prev_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      csync_r      <= 1'b0;
      csync_prev_r <= 1'b0;
    end
    else
    begin
      csync_r      <= below_thr;
      csync_prev_r <= csync_r;
    end
  end

  assign csync_out = csync_r;

  // one setting scales both rates; zero is taken as the smallest step
  assign res_eff    = (timing_resistor == 8'h00) ? 8'h01
                                                 : timing_resistor;
  assign int_period = TICK_W'({5'h00, res_eff} * INT_SCALE);
  assign osc_period = TICK_W'({5'h00, res_eff} * OSC_SCALE);

  vse_tick_gen u_int_rate (
    .clk    (clk),
    .rst    (rst),
    .run    (csync_r),
    .period (int_period),
    .tick   (int_tick)
  );

  vse_integrator u_integ (
    .clk        (clk),
    .rst        (rst),
    .charge     (csync_r),
    .step       (int_tick),
    .level      (integ_level),
    .above_serr (above_serr),
    .above_dflt (above_dflt)
  );

  // the level still holds the pulse's charge in the cycle that
  // sees sync end; it clears one cycle later
  assign sample_nxt = sync_end ? above_serr : sample_r;
  assign samp_set   = sync_end && above_serr;
  assign dflt_rise  = above_dflt && !dflt_prev_r;
  // edge-set rather than level-set, so a stale high sample cannot
  // restart the pulse on its own once the divider has run out
  assign set_term   = samp_set || dflt_rise;

  assign osc_run = vstate_r == VSE_PULSE;

  vse_tick_gen u_osc (
    .clk    (clk),
    .rst    (rst),
    .run    (osc_run),
    .period (osc_period),
    .tick   (osc_tick)
  );

  assign div_end = osc_run && osc_tick && div_cnt_r == DIV_LAST;

  always_comb
  begin
    vstate_nxt  = vstate_r;
    div_cnt_nxt = div_cnt_r;
    case (vstate_r)
      VSE_IDLE:
      begin
        div_cnt_nxt = 3'h0;
        if (set_term)
          vstate_nxt = VSE_PULSE;
      end
      VSE_PULSE:
      begin
        if (div_end && set_term)
          div_cnt_nxt = 3'h0;
        else if (div_end)
        begin
          vstate_nxt  = VSE_IDLE;
          div_cnt_nxt = 3'h0;
        end
        else if (osc_tick)
          div_cnt_nxt = div_cnt_r + 3'h1;
      end
      default:
      begin
        vstate_nxt  = VSE_IDLE;
        div_cnt_nxt = 3'h0;
      end
    endcase
  end

  assign vsync_rise = (vstate_r == VSE_IDLE) && set_term;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      vstate_r    <= VSE_IDLE;
      div_cnt_r   <= 3'h0;
      vsync_r     <= 1'b0;
      sample_r    <= 1'b0;
      dflt_prev_r <= 1'b0;
    end
    else
    begin
      vstate_r    <= vstate_nxt;
      div_cnt_r   <= div_cnt_nxt;
      vsync_r     <= vstate_nxt == VSE_PULSE;
      sample_r    <= sample_nxt;
      dflt_prev_r <= above_dflt;
    end
  end

  assign vsync_out = vsync_r;

  // field parity: toggle on every half-line gap, clear on a full
  // line; the half line closing the odd field flips the phase
  assign long_gap    = gap_cnt_r >= PARITY_GAP_CYC;
  assign gap_cnt_nxt = sync_start ? 12'h000 :
                       long_gap ? gap_cnt_r : gap_cnt_r + 12'h001;
  assign half_nxt    = !sync_start ? half_r :
                       long_gap ? 1'b0 : !half_r;
  assign field_odd_nxt = vsync_rise ? half_r : field_odd_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      gap_cnt_r   <= 12'h000;
      half_r      <= 1'b0;
      field_odd_r <= 1'b0;
    end
    else
    begin
      gap_cnt_r   <= gap_cnt_nxt;
      half_r      <= half_nxt;
      field_odd_r <= field_odd_nxt;
    end
  end

  assign field_odd_out = field_odd_r;

  a_csync_slice: assert property (@(posedge clk) disable iff (rst)
    !below_thr |=> !csync_out) else $error("picture on csync");
  a_thr_offset: assert property (@(posedge clk) disable iff (rst)
    !thr_sum[VID_W] |-> thr_sat == tip_r + SLICE_OFFSET_CODES[7:0])
    else $error("slice offset wrong");
  a_sample_edge: assert property (@(posedge clk) disable iff (rst)
    sync_end |=> sample_r == $past(above_serr))
    else $error("sample not taken");
  a_latch_set: assert property (@(posedge clk) disable iff (rst)
    set_term && !vsync_out |=> vsync_out ##1 vsync_out)
    else $error("latch not set");
  a_osc_follow: assert property (@(posedge clk) disable iff (rst)
    osc_run |-> ##1 (vsync_out || $past(div_end)))
    else $error("oscillator outside pulse");
  a_div_clear: assert property (@(posedge clk) disable iff (rst)
    div_end && !set_term |=> !vsync_out)
    else $error("latch not cleared");
  a_no_trigger: assert property (@(posedge clk) disable iff (rst)
    !vsync_out && !set_term |=> !vsync_out)
    else $error("pulse without trigger");
  a_dflt_start: assert property (@(posedge clk) disable iff (rst)
    dflt_rise && !vsync_out |=> vsync_out)
    else $error("default did not start");
  a_parity_hold: assert property (@(posedge clk) disable iff (rst)
    !vsync_rise |=> $stable(field_odd_out))
    else $error("parity moved mid field");

  // a set seen while the pulse runs is dropped rather than queued, unless it falls in the
  // div_end cycle, where it restarts the divider; else a second pulse needs a fresh set edge after the clear
  a_csync_follow: assert property (@(posedge clk) disable iff (rst)
    below_thr |=> csync_out)
    else $error("sync not passed");
  a_tip_follow: assert property (@(posedge clk) disable iff (rst)
    vid_r < tip_r |=> tip_r == $past(vid_r))
    else $error("clamp did not follow tip");
  a_start_clear: assert property (@(posedge clk) disable iff (rst)
    sync_start |-> integ_level == 8'h00)
    else $error("charge left from last pulse");
  a_short_sync: assert property (@(posedge clk) disable iff (rst)
    sync_end && !above_serr |-> !set_term)
    else $error("short sync set the latch");
  a_serr_set: assert property (@(posedge clk) disable iff (rst)
    samp_set |-> vstate_nxt == VSE_PULSE)
    else $error("sample did not set latch");
  a_osc_gated: assert property (@(posedge clk) disable iff (rst)
    !osc_run |-> !osc_tick)
    else $error("oscillator ticks while idle");
  a_div_step: assert property (@(posedge clk) disable iff (rst)
    osc_tick && div_cnt_r != DIV_LAST |=>
    vsync_out && div_cnt_r == $past(div_cnt_r) + 3'h1)
    else $error("divider did not step");
  a_serr_retrigger: assert property (@(posedge clk) disable iff (rst)
    vstate_r == VSE_IDLE && samp_set |=> vsync_out && div_cnt_r == 3'h0)
    else $error("serration did not retrigger");
  a_parity_take: assert property (@(posedge clk) disable iff (rst)
    vsync_rise |=> field_odd_out == $past(half_r))
    else $error("parity not taken at rise");
endmodule // vse_sync_extractor

// File: dv/vse_video_src.sv
// composite video source model feeding the extractor
`timescale 1ns/1ps
module vse_video_src
  import vse_pkg::*;
(
  // clock
  input  wire logic                    clk,
  // video and status
  output logic [vse_pkg::VID_W-1:0]    video,
  output logic                         busy
);
  typedef struct { int s; int p; } vse_seg_type;
  localparam logic [VID_W-1:0] TIP = 8'h10;
  vse_seg_type q[$];
  int          s_left = 0;
  int          p_left = 0;
  // queue n sync pulses of s cycles, one every p cycles
  task automatic send(input int s, input int p, input int n);
    repeat (n) q.push_back('{s, p});
  endtask
  initial
  begin
    video = 8'h90;
    busy = 1'b0;
  end
  // picture changes every cycle so a stale sample never looks right
  always @(negedge clk)
  begin
    if (p_left == 0 && q.size() != 0)
    begin
      s_left = q[0].s;
      p_left = q[0].p;
      void'(q.pop_front());
    end
    // sync samples spread over the whole slicing window above the tip
    if (s_left != 0)
      video <= TIP + 8'($urandom_range(0, int'(SLICE_OFFSET_CODES)));
    else
      video <= 8'h90 + 8'($urandom_range(0, 111));
    if (s_left != 0)
      s_left--;
    if (p_left != 0)
      p_left--;
    busy <= (p_left != 0) || (q.size() != 0);
  end
endmodule // vse_video_src

// File: dv/vertical_sync_extractor_test.sv
// self-checking bench for the vertical sync extractor
`timescale 1ns/1ps
module vertical_sync_extractor_test;
  import vse_pkg::*;
  logic             clk;
  logic             rst;
  logic [VID_W-1:0] video;
  logic [RES_W-1:0] timing_resistor;
  logic             csync_out;
  logic             vsync_out;
  logic             field_odd_out;
  logic             busy;
  logic             chk_on;
  logic             v_prev;
  logic             fo_rise;
  logic             fo_last;
  logic [VID_W-1:0] v1;
  logic [VID_W-1:0] v2;
  int               n_errors;
  int               checks_done;
  int               cyc;
  int               rises;
  int               rise_cyc;
  int               hi_cnt;
  int               width;
  int               t0;
  int               r;
  int               n;

  vse_sync_extractor vse_sync_extractor_inst (
    .clk            (clk),
    .rst            (rst),
    .video_in       (video),
    .timing_resistor(timing_resistor),
    .csync_out      (csync_out),
    .vsync_out      (vsync_out),
    .field_odd_out  (field_odd_out)
  );
  vse_video_src vse_video_src_inst (
    .clk  (clk),
    .video(video),
    .busy (busy)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_near(input int got, input int exp, input int tol);
    checks_done++;
    if (got < exp - tol || got > exp + tol)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic csync_exp(input logic [VID_W-1:0] v);
    return v <= vse_video_src_inst.TIP + SLICE_OFFSET_CODES[VID_W-1:0];
  endfunction

  function automatic int width_exp(input int rr);
    return (int'(DIV_LAST) + 1) * int'(OSC_SCALE) * rr + 2;
  endfunction

  // mid-cycle sampling; latency unknown to one cycle, so only steady runs
  always @(negedge clk)
  begin
    cyc++;
    if (chk_on && csync_exp(v1) === csync_exp(v2))
      check_eq(csync_out, csync_exp(v1));
    v2 = v1;
    v1 = video;
    if (vsync_out === 1'b1)
    begin
      if (v_prev !== 1'b1)
      begin
        rises++;
        rise_cyc = cyc;
        fo_rise = field_odd_out;
        hi_cnt = 0;
      end
      hi_cnt++;
    end
    else if (v_prev === 1'b1)
      width = hi_cnt;
    v_prev = vsync_out;
  end

  task automatic start(input int rr);
    @(negedge clk);
    timing_resistor <= 8'(rr);
    @(posedge clk);
    rises = 0;
    t0 = cyc;
  endtask

  // idle lines let a pending pulse finish before the next case
  task automatic settle();
    int i;
    vse_video_src_inst.send(8, 64, 12);
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end while (busy !== 1'b0 && i < 40000);
    if (i >= 40000)
    begin
      n_errors++;
      conclude();
    end
  endtask

  task automatic run(input int rr, input int s, input int p, input int k);
    start(rr);
    vse_video_src_inst.send(s, p, k);
    settle();
  endtask

  // half selects a field that follows a half line
  task automatic field(input int half);
    start(68);
    vse_video_src_inst.send(235, 3200, 2 - half);
    vse_video_src_inst.send(235, 1600, half);
    vse_video_src_inst.send(115, 1600, 3);
    vse_video_src_inst.send(1360, 1600, 3);
    vse_video_src_inst.send(115, 1600, 3);
    vse_video_src_inst.send(235, 3200, 2);
    settle();
  endtask

  initial
  begin
    rst = 1'b1;
    timing_resistor = 8'h01;
    chk_on = 1'b0;
    v_prev = 1'b0;
    v1 = 8'h90;
    v2 = 8'h90;
    n_errors = 0;
    checks_done = 0;
    cyc = 0;
    rises = 0;
    width = 0;
    r = $urandom(32'h5265cb1c);
    repeat (2) @(negedge clk);
    rst <= 1'b0;
    run(1, 8, 64, 4);
    chk_on = 1'b1;
    run(1, 8, 64, 20);
    check_eq(rises, 0);
    run(8, 30, 32, 6);
    check_eq(rises, 0);
    for (int k = 0; k < 5; k++)
    begin
      r = (k < 2) ? k + 1 : $urandom_range(1, 2);
      n = (k < 2) ? 5 + k : $urandom_range(1, 5);
      run(r, 30, 32, n);
      check_eq(rises, 1);
      check_near(rise_cyc - t0, 35, 4);
      check_near(width, width_exp(r), 3);
    end
    run(1, 30, 32, 12);
    check_eq(rises, 2);
    run(1, 100, 300, 1);
    check_eq(rises, 1);
    check_near(rise_cyc - t0, 45, 5);
    run(1, 350, 600, 1);
    check_eq(rises, 2);
    check_near(rise_cyc - t0, 354, 5);
    for (int f = 0; f < 3; f++)
    begin
      field(f % 2);
      check_eq(rises, 1);
      check_near(width, width_exp(68), 4);
      check_eq(field_odd_out, fo_rise);
      check_eq(fo_rise, f % 2 == 0);
      if (f > 0)
        check_eq(fo_rise, !fo_last);
      fo_last = fo_rise;
    end
    conclude();
  end
endmodule // vertical_sync_extractor_test
